// *** src/fcss_pkg.sv ***
package fcss_pkg;

  // Register byte offsets
  localparam logic [11:0] FCSS_CTRL_OFS = 12'h000;
  localparam logic [11:0] FCSS_STATUS_OFS = 12'h004;
  localparam logic [11:0] FCSS_LENGTH_OFS = 12'h008;
  localparam logic [11:0] FCSS_COUNT_OFS = 12'h00C;

  // Control register fields
  localparam int FCSS_CTRL_SKIP_CLEAR_POS = 0;
  localparam int FCSS_CTRL_SU_MODE_POS = 1;
  localparam int FCSS_CTRL_DONE_PU_POS = 3;
  localparam int FCSS_CTRL_FF_DLY_POS = 4;
  localparam int FCSS_CTRL_IO_DLY_POS = 8;
  localparam int FCSS_CTRL_DONE_DLY_POS = 12;

  // Status register fields
  localparam int FCSS_STAT_STATE_POS = 0;
  localparam int FCSS_STAT_MODE_POS = 4;
  localparam int FCSS_STAT_LOADED_POS = 8;
  localparam int FCSS_STAT_FF_REL_POS = 9;
  localparam int FCSS_STAT_IO_ON_POS = 10;
  localparam int FCSS_STAT_MASTER_POS = 11;
  localparam int FCSS_STAT_WPTR_POS = 16;

  // Start-up modes: bit 0 synchronised, bit 1 user clock
  typedef enum logic [1:0] {
    load_clock_free,
    load_clock_synced,
    user_clock_free,
    user_clock_synced
  } fcss_su_mode_t;

  // Reset values
  localparam logic FCSS_SKIP_CLEAR_RST = 1'b0;
  localparam fcss_su_mode_t FCSS_SU_MODE_RST = load_clock_synced;
  localparam logic FCSS_DONE_PU_RST = 1'b1;
  localparam logic [2:0] FCSS_DLY_RST = 3'h0;
  localparam logic [2:0] FCSS_DLY_MAX = 3'h4;

  // Sampled mode bit that selects a master mode
  localparam int FCSS_MODE_MASTER_POS = 2;

  // Timing
  localparam int FCSS_CLK_NS = 50;
  localparam int FCSS_INIT_TIMEOUT_NS = 200;
  localparam int FCSS_INIT_TIMEOUT_CYC = (FCSS_INIT_TIMEOUT_NS + FCSS_CLK_NS - 1) / FCSS_CLK_NS;
  localparam logic [3:0] FCSS_PREP_HIGH_CYC = 4'h2;
  localparam logic [3:0] FCSS_MASTER_EXTRA_CYC = 4'h6;
  localparam logic [2:0] FCSS_LCLK_HALF_CYC = 3'h4;

  // Load stream layout
  localparam logic [5:0] FCSS_HDR_LEN_FIRST = 6'h08;
  localparam logic [5:0] FCSS_HDR_LAST = 6'h1F;
  localparam logic [7:0] FCSS_STOP_BYTE = 8'hFF;
  localparam int FCSS_MEM_WORDS = 16;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_WAIT_PREP,
    ST_CONFIG,
    ST_STARTUP,
    ST_OPERATE
  } fcss_state_t;

endpackage : fcss_pkg

// *** src/fcss_sync.sv ***
`timescale 1ns/1ns
module fcss_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fcss_sync_st_t;

  fcss_sync_st_t st_q;
  fcss_sync_st_t st_d;

  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule : fcss_sync

// *** src/fcss_sequencer.sv ***
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
module fcss_sequencer
  import fcss_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic device_reset_n,
  input wire logic reload_request_n,
  input wire logic prep_complete_n_i,
  output logic prep_complete_n_o,
  output logic prep_complete_n_oe,
  input wire logic start_finished_i,
  output logic start_finished_o,
  output logic start_finished_oe,
  output logic start_finished_pullup_en,
  input wire logic [3:0] mode_select_pins,
  input wire logic load_clock_i,
  output logic load_clock_o,
  output logic load_clock_oe,
  input wire logic user_startup_clock,
  input wire logic config_data,
  output logic high_while_loading,
  output logic low_while_loading,
  output logic io_hiz_pullup,
  output logic cell_hold_setreset,
  output logic bidir_hiz,
  output logic user_io_active
);

  typedef struct packed {
    fcss_state_t st;
    logic [2:0] tmr;
    logic [3:0] hi_cnt;
    logic [3:0] mode;
    logic master;
    logic first_load_done;
    logic od_low;
    logic prep_oe;
    logic done_oe;
    logic hi_load;
    logic lo_load;
    logic io_hiz;
    logic cell_hold;
    logic bidir_hiz;
    logic io_on;
    logic [2:0] div;
    logic lclk_o;
    logic lclk_oe;
    logic lclk_prev;
    logic ustart_prev;
    logic [23:0] clk_cnt;
    logic [23:0] length;
    logic [5:0] hdr_bits;
    logic hdr_done;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [3:0] wptr;
    logic ff_byte;
    logic end_seen;
    logic [FCSS_MEM_WORDS-1:0][7:0] mem;
    logic [2:0] s_edges;
    logic done_seen;
    logic [2:0] rel_edges;
    logic skip_clear;
    fcss_su_mode_t su_mode;
    logic done_pu;
    logic [2:0] ff_dly;
    logic [2:0] io_dly;
    logic [2:0] done_dly;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fcss_core_t;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Values forced whenever initialisation is (re)entered
  function automatic fcss_core_t fcss_enter_init(input fcss_core_t c);
    fcss_core_t r;
    r = c;
    r.st = ST_INIT;
    r.tmr = 3'h0;
    r.hi_cnt = 4'h0;
    r.prep_oe = 1'b1;
    r.done_oe = 1'b1;
    r.hi_load = 1'b1;
    r.lo_load = 1'b0;
    r.io_hiz = 1'b1;
    r.cell_hold = 1'b1;
    r.bidir_hiz = 1'b1;
    r.io_on = 1'b0;
    r.lclk_oe = 1'b0;
    r.lclk_o = 1'b0;
    r.div = 3'h0;
    return r;
  endfunction : fcss_enter_init

  // Edge count has reached one past a programmed delay
  function automatic logic fcss_reached(input logic [2:0] cnt, input logic [2:0] dly);
    return {1'b0, cnt} >= ({1'b0, dly} + 4'h1);
  endfunction : fcss_reached

  function automatic logic [2:0] fcss_clamp_dly(input logic [2:0] v);
    return (v > FCSS_DLY_MAX) ? FCSS_DLY_MAX : v;
  endfunction : fcss_clamp_dly

  function automatic logic [2:0] fcss_sat_inc(input logic [2:0] v);
    return (v == 3'h7) ? v : v + 3'h1;
  endfunction : fcss_sat_inc

  localparam fcss_core_t FCSS_CORE_RST = '{
    st: ST_INIT,
    prep_oe: 1'b1,
    done_oe: 1'b1,
    hi_load: 1'b1,
    io_hiz: 1'b1,
    cell_hold: 1'b1,
    bidir_hiz: 1'b1,
    skip_clear: FCSS_SKIP_CLEAR_RST,
    su_mode: FCSS_SU_MODE_RST,
    done_pu: FCSS_DONE_PU_RST,
    ff_dly: FCSS_DLY_RST,
    io_dly: FCSS_DLY_RST,
    done_dly: FCSS_DLY_RST,
    default: '0
  };

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [10:0] sync_q;
  logic rst_in;
  logic reload_in;
  logic prep_in;
  logic done_in;
  logic lclk_in;
  logic ustart_in;
  logic data_in;
  logic [3:0] mode_in;

  fcss_sync #(
    .W(11)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({device_reset_n, reload_request_n, prep_complete_n_i, start_finished_i,
        load_clock_i, user_startup_clock, config_data, mode_select_pins}),
    .q(sync_q)
  );

  assign {rst_in, reload_in, prep_in, done_in, lclk_in, ustart_in, data_in, mode_in} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  fcss_core_t c_q;
  fcss_core_t c_d;

  always_comb
  begin
    logic lclk_rise;
    logic su_edge;
    logic apb_setup;
    logic apb_write;
    logic [3:0] nh;
    logic [7:0] byte_v;
    c_d = c_q;
    lclk_rise = 1'b0;
    su_edge = 1'b0;
    nh = 4'h0;
    byte_v = 8'h00;
    apb_setup = psel && !penable;
    apb_write = psel && penable && c_q.pready && pwrite;

    // Load clock: own divider in master modes, sampled pin otherwise
    c_d.lclk_prev = lclk_in;
    c_d.ustart_prev = ustart_in;
    if (c_q.lclk_oe)
    begin
      if (c_q.div == FCSS_LCLK_HALF_CYC - 3'h1)
      begin
        c_d.div = 3'h0;
        c_d.lclk_o = !c_q.lclk_o;
        lclk_rise = !c_q.lclk_o;
      end
      else
      begin
        c_d.div = c_q.div + 3'h1;
      end
    end
    else
    begin
      lclk_rise = lclk_in && !c_q.lclk_prev;
    end
    su_edge = c_q.su_mode[1] ? (ustart_in && !c_q.ustart_prev) : lclk_rise;

    unique case (c_q.st)
      ST_INIT:
      begin
        if (c_q.tmr == 3'(FCSS_INIT_TIMEOUT_CYC - 1))
        begin
          if (!(c_q.skip_clear && c_q.first_load_done))
          begin
            c_d.mem = '0;
          end
          c_d.prep_oe = 1'b0;
          c_d.hi_cnt = 4'h0;
          c_d.st = ST_WAIT_PREP;
        end
        else
        begin
          c_d.tmr = c_q.tmr + 3'h1;
        end
      end
      ST_WAIT_PREP:
      begin
        if (!prep_in || !rst_in || !reload_in)
        begin
          c_d.hi_cnt = 4'h0;
        end
        else
        begin
          nh = c_q.hi_cnt + 4'h1;
          c_d.hi_cnt = nh;
          if (nh == FCSS_PREP_HIGH_CYC)
          begin
            c_d.mode = mode_in;
            c_d.master = mode_in[FCSS_MODE_MASTER_POS];
          end
          if ((nh == FCSS_PREP_HIGH_CYC && !mode_in[FCSS_MODE_MASTER_POS]) ||
              (nh == FCSS_PREP_HIGH_CYC + FCSS_MASTER_EXTRA_CYC && c_q.master))
          begin
            c_d.st = ST_CONFIG;
            c_d.lclk_oe = c_d.master;
            c_d.clk_cnt = 24'h000000;
            c_d.length = 24'h000000;
            c_d.hdr_bits = 6'h00;
            c_d.hdr_done = 1'b0;
            c_d.bit_cnt = 3'h0;
            c_d.wptr = 4'h0;
            c_d.ff_byte = 1'b0;
            c_d.end_seen = 1'b0;
          end
        end
      end
      ST_CONFIG:
      begin
        if (!rst_in || !reload_in)
        begin
          c_d = fcss_enter_init(c_d);
        end
        else
        begin
          if (lclk_rise)
          begin
            c_d.clk_cnt = c_q.clk_cnt + 24'h000001;
            if (!c_q.hdr_done)
            begin
              c_d.hdr_bits = c_q.hdr_bits + 6'h01;
              if (c_q.hdr_bits >= FCSS_HDR_LEN_FIRST)
              begin
                c_d.length = {c_q.length[22:0], data_in};
              end
              c_d.hdr_done = (c_q.hdr_bits == FCSS_HDR_LAST);
            end
            else
            begin
              byte_v = {c_q.shift[6:0], data_in};
              c_d.shift = byte_v;
              c_d.bit_cnt = c_q.bit_cnt + 3'h1;
              if (c_q.bit_cnt == 3'h7)
              begin
                c_d.mem[c_q.wptr] = byte_v;
                c_d.wptr = c_q.wptr + 4'h1;
                c_d.ff_byte = (byte_v == FCSS_STOP_BYTE);
                if (c_q.ff_byte && byte_v == FCSS_STOP_BYTE)
                begin
                  c_d.end_seen = 1'b1;
                end
              end
            end
          end
          if (c_q.hdr_done && c_q.end_seen && c_q.clk_cnt == c_q.length)
          begin
            c_d.st = ST_STARTUP;
            c_d.first_load_done = 1'b1;
            c_d.s_edges = 3'h0;
            c_d.rel_edges = 3'h0;
            c_d.done_seen = 1'b0;
            c_d.hi_load = 1'b0;
            c_d.lo_load = 1'b1;
          end
        end
      end
      ST_STARTUP:
      begin
        if (!reload_in)
        begin
          c_d = fcss_enter_init(c_d);
        end
        else
        begin
          if (su_edge)
          begin
            c_d.s_edges = fcss_sat_inc(c_q.s_edges);
            if (c_q.done_seen)
            begin
              c_d.rel_edges = fcss_sat_inc(c_q.rel_edges);
            end
          end
          if (fcss_reached(c_d.s_edges, c_q.done_dly))
          begin
            c_d.done_oe = 1'b0;
          end
          if (done_in && !c_q.done_oe)
          begin
            c_d.done_seen = 1'b1;
          end
          if (c_q.su_mode[0])
          begin
            if (c_q.done_seen && c_q.rel_edges >= c_q.ff_dly)
            begin
              c_d.cell_hold = 1'b0;
              c_d.bidir_hiz = 1'b0;
            end
            if (c_q.done_seen && c_q.rel_edges >= c_q.io_dly)
            begin
              c_d.io_on = 1'b1;
              c_d.io_hiz = 1'b0;
            end
          end
          else
          begin
            if (fcss_reached(c_d.s_edges, c_q.ff_dly))
            begin
              c_d.cell_hold = 1'b0;
              c_d.bidir_hiz = 1'b0;
            end
            if (fcss_reached(c_d.s_edges, c_q.io_dly))
            begin
              c_d.io_on = 1'b1;
              c_d.io_hiz = 1'b0;
            end
          end
          if (!c_q.done_oe && !c_q.cell_hold && c_q.io_on)
          begin
            c_d.st = ST_OPERATE;
            c_d.lclk_oe = 1'b0;
          end
        end
      end
      ST_OPERATE:
      begin
        if (!reload_in)
        begin
          c_d = fcss_enter_init(c_d);
        end
      end
    endcase

    // APB slave: answer registered in the setup cycle, one access cycle
    c_d.pready = apb_setup;
    c_d.pslverr = 1'b0;
    if (apb_setup)
    begin
      c_d.prdata = 32'h00000000;
      unique case (paddr)
        FCSS_CTRL_OFS:
        begin
          c_d.prdata[FCSS_CTRL_SKIP_CLEAR_POS] = c_q.skip_clear;
          c_d.prdata[FCSS_CTRL_SU_MODE_POS +: 2] = c_q.su_mode;
          c_d.prdata[FCSS_CTRL_DONE_PU_POS] = c_q.done_pu;
          c_d.prdata[FCSS_CTRL_FF_DLY_POS +: 3] = c_q.ff_dly;
          c_d.prdata[FCSS_CTRL_IO_DLY_POS +: 3] = c_q.io_dly;
          c_d.prdata[FCSS_CTRL_DONE_DLY_POS +: 3] = c_q.done_dly;
        end
        FCSS_STATUS_OFS:
        begin
          c_d.prdata[FCSS_STAT_STATE_POS +: 3] = c_q.st;
          c_d.prdata[FCSS_STAT_MODE_POS +: 4] = c_q.mode;
          c_d.prdata[FCSS_STAT_LOADED_POS] = c_q.first_load_done;
          c_d.prdata[FCSS_STAT_FF_REL_POS] = !c_q.cell_hold;
          c_d.prdata[FCSS_STAT_IO_ON_POS] = c_q.io_on;
          c_d.prdata[FCSS_STAT_MASTER_POS] = c_q.master;
          c_d.prdata[FCSS_STAT_WPTR_POS +: 4] = c_q.wptr;
        end
        FCSS_LENGTH_OFS:
        begin
          c_d.prdata[23:0] = c_q.length;
        end
        FCSS_COUNT_OFS:
        begin
          c_d.prdata[23:0] = c_q.clk_cnt;
        end
        default:
        begin
          c_d.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_write && paddr == FCSS_CTRL_OFS)
    begin
      c_d.skip_clear = pwdata[FCSS_CTRL_SKIP_CLEAR_POS];
      c_d.su_mode = fcss_su_mode_t'(pwdata[FCSS_CTRL_SU_MODE_POS +: 2]);
      c_d.done_pu = pwdata[FCSS_CTRL_DONE_PU_POS];
      c_d.ff_dly = fcss_clamp_dly(pwdata[FCSS_CTRL_FF_DLY_POS +: 3]);
      c_d.io_dly = fcss_clamp_dly(pwdata[FCSS_CTRL_IO_DLY_POS +: 3]);
      c_d.done_dly = fcss_clamp_dly(pwdata[FCSS_CTRL_DONE_DLY_POS +: 3]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c_q <= FCSS_CORE_RST;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = c_q.prdata;
  assign pready = c_q.pready;
  assign pslverr = c_q.pslverr;
  assign prep_complete_n_o = c_q.od_low;
  assign prep_complete_n_oe = c_q.prep_oe;
  assign start_finished_o = c_q.od_low;
  assign start_finished_oe = c_q.done_oe;
  assign start_finished_pullup_en = c_q.done_pu;
  assign load_clock_o = c_q.lclk_o;
  assign load_clock_oe = c_q.lclk_oe;
  assign high_while_loading = c_q.hi_load;
  assign low_while_loading = c_q.lo_load;
  assign io_hiz_pullup = c_q.io_hiz;
  assign cell_hold_setreset = c_q.cell_hold;
  assign bidir_hiz = c_q.bidir_hiz;
  assign user_io_active = c_q.io_on;

endmodule : fcss_sequencer

// *** verification/fcss_sequencer_properties.sv ***
`timescale 1ns/1ns
module fcss_sequencer_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reload_request_n,
  input wire logic prep_complete_n_o,
  input wire logic prep_complete_n_oe,
  input wire logic start_finished_o,
  input wire logic start_finished_oe,
  input wire logic high_while_loading,
  input wire logic low_while_loading,
  input wire logic io_hiz_pullup,
  input wire logic cell_hold_setreset,
  input wire logic bidir_hiz,
  input wire logic user_io_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  error_data_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("read data not zero on error");
  prep_drain_a: assert property (prep_complete_n_o == 1'b0)
    else $error("ready line driven high");
  finished_drain_a: assert property (start_finished_o == 1'b0)
    else $error("finished line driven high");
  init_release_a: assert property ($rose(presetn) |-> prep_complete_n_oe[*3] ##[1:4] !prep_complete_n_oe)
    else $error("ready line not released after init");
  loading_flags_a: assert property (high_while_loading |-> !low_while_loading && start_finished_oe)
    else $error("loading flags inconsistent");
  loading_hold_a: assert property (high_while_loading |-> cell_hold_setreset && bidir_hiz && io_hiz_pullup && !user_io_active)
    else $error("cells or io free while loading");
  finished_late_a: assert property ($fell(start_finished_oe) |-> !high_while_loading)
    else $error("finished released while loading");
  bidir_with_cells_a: assert property ($fell(cell_hold_setreset) |-> $fell(bidir_hiz))
    else $error("bidir buffers not released with cells");
  io_pullup_off_a: assert property ($rose(user_io_active) |-> !io_hiz_pullup)
    else $error("io active while tristated");
  operate_hold_a: assert property (user_io_active && reload_request_n && $past(reload_request_n)
    && $past(reload_request_n, 2) && $past(reload_request_n, 3) |=> user_io_active)
    else $error("operation left without reload");
endmodule : fcss_sequencer_properties

bind fcss_sequencer fcss_sequencer_properties fcss_sequencer_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .reload_request_n(reload_request_n),
  .prep_complete_n_o(prep_complete_n_o), .prep_complete_n_oe(prep_complete_n_oe),
  .start_finished_o(start_finished_o), .start_finished_oe(start_finished_oe),
  .high_while_loading(high_while_loading), .low_while_loading(low_while_loading),
  .io_hiz_pullup(io_hiz_pullup), .cell_hold_setreset(cell_hold_setreset),
  .bidir_hiz(bidir_hiz), .user_io_active(user_io_active));

// *** verification/fcss_source_model.sv ***
`timescale 1ns/1ns
module fcss_source_model (
  input wire logic start,
  output logic load_clock,
  output logic data,
  output logic done
);
  // Preamble, length 56, one data byte, end frame, then start-up clocks
  localparam logic [63:0] STREAM = {8'hF2, 24'h000038, 8'h5A, 8'hFF, 8'hFF, 8'hFF};
  initial
  begin
    load_clock = 1'b0;
    data = 1'b0;
    done = 1'b0;
  end
  // Clock runs only within the stream
  always @(posedge start)
  begin
    done = 1'b0;
    #13;
    for (int i = 63; i >= 0; i--)
    begin
      data = STREAM[i];
      #200 load_clock = 1'b1;
      #200 load_clock = 1'b0;
    end
    data = ~data;
    done = 1'b1;
  end
endmodule : fcss_source_model

// *** verification/fcss_sequencer_tb_top.sv ***
`timescale 1ns/1ns
module fcss_sequencer_tb_top
  import fcss_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic dev_rst_n, reload_n, prep_hold, sf_hold, src_start, src_done, lclk, cdata;
  logic prep_oe, prep_o, sf_oe, sf_o, sf_pu, lclk_o, lclk_oe, lclk_was;
  logic hwl, lwl, io_hiz, cell_hold, bidir_hiz, io_act;
  logic [3:0] mode_pins;
  int fail_count, checked;
  wire prep_line = !prep_oe && !prep_hold;
  wire sf_line = !sf_oe && !sf_hold;

  fcss_sequencer fcss_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_reset_n(dev_rst_n), .reload_request_n(reload_n),
    .prep_complete_n_i(prep_line), .prep_complete_n_o(prep_o), .prep_complete_n_oe(prep_oe),
    .start_finished_i(sf_line), .start_finished_o(sf_o), .start_finished_oe(sf_oe),
    .start_finished_pullup_en(sf_pu), .mode_select_pins(mode_pins), .load_clock_i(lclk),
    .load_clock_o(lclk_o), .load_clock_oe(lclk_oe), .user_startup_clock(1'b0),
    .config_data(cdata), .high_while_loading(hwl), .low_while_loading(lwl),
    .io_hiz_pullup(io_hiz), .cell_hold_setreset(cell_hold), .bidir_hiz(bidir_hiz),
    .user_io_active(io_act));

  fcss_source_model fcss_source_model_inst (
    .start(src_start), .load_clock(lclk), .data(cdata), .done(src_done));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, FCSS_STATUS_OFS, 32'h0);
      n++;
    end
    while (rd[2:0] !== s && n < 400);
    check("state", {29'h0, rd[2:0]}, {29'h0, s});
  endtask : wait_state

  task close_out;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    #500000;
    fail_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {dev_rst_n, reload_n, prep_hold, sf_hold, src_start} = 5'h1C;
    mode_pins = 4'h3;
    @(negedge pclk);
    check("reset outputs", {prep_oe, sf_oe, hwl, lwl, io_hiz, cell_hold, bidir_hiz, io_act,
      lclk_oe}, 9'h1DC);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FCSS_CTRL_OFS, 32'h0);
    check("ctrl reset", rd, 32'h0000_000A);
    check("pull-up", sf_pu, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, FCSS_CTRL_OFS, 32'h0000_7779);
    apb(1'b0, FCSS_CTRL_OFS, 32'h0);
    check("ctrl clamp", rd, 32'h0000_4449);
    apb(1'b1, FCSS_CTRL_OFS, 32'h0000_000A);
    $display("test defaults done");

    repeat (20) @(posedge pclk);
    wait_state(3'h1);
    prep_hold <= 1'b0;
    wait_state(3'h2);
    check("mode", rd[11:4], {4'h0, 4'h3});
    check("config outputs", {hwl, lwl, sf_oe, io_hiz, cell_hold, lclk_oe}, 6'h2E);
    $display("test init done");

    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        dev_rst_n <= 1'b0;
      else
        reload_n <= 1'b0;
      repeat (40) @(posedge pclk);
      wait_state(3'h1);
      dev_rst_n <= 1'b1;
      reload_n <= 1'b1;
      wait_state(3'h2);
    end
    $display("test abort done");

    sf_hold <= 1'b1;
    src_start <= 1'b1;
    for (int n = 0; n < 4000 && src_done !== 1'b1; n++)
      @(posedge pclk);
    repeat (20) @(posedge pclk);
    wait_state(3'h3);
    check("held start-up", {cell_hold, io_act, sf_oe}, 3'h4);
    apb(1'b0, FCSS_LENGTH_OFS, 32'h0);
    check("length", rd, 32'h0000_0038);
    sf_hold <= 1'b0;
    wait_state(3'h4);
    check("operate outputs", {hwl, lwl, cell_hold, bidir_hiz, io_hiz, io_act, sf_oe},
      7'h22);
    check("status flags", rd[10:8], 3'h7);
    check("words", rd[19:16], 4'h3);
    apb(1'b0, FCSS_COUNT_OFS, 32'h0);
    check("count", rd, 32'h0000_0038);
    $display("test load done");

    dev_rst_n <= 1'b0;
    repeat (30) @(posedge pclk);
    wait_state(3'h4);
    check("io kept", io_act, 1'b1);
    dev_rst_n <= 1'b1;
    mode_pins <= 4'h5;
    reload_n <= 1'b0;
    repeat (10) @(posedge pclk);
    reload_n <= 1'b1;
    wait_state(3'h2);
    check("reload mode", rd[7:4], 4'h5);
    check("master", {rd[11], lclk_oe}, 2'h3);
    lclk_was = lclk_o;
    repeat (4) @(posedge pclk);
    check("load clock", lclk_o, !lclk_was);
    check("reload outputs", {hwl, io_hiz, io_act}, 3'h6);
    $display("test reload done");
    close_out();
  end
endmodule : fcss_sequencer_tb_top
